// file: bench/sfp_flash_front_chk.sv
// port assertions for the flash front end
// assumes binding into sfp_flash_front with BUSY_CYCLES of 8 or more
`timescale 1ns/10ps
module sfp_flash_front_chk
  import sfp_pkg::*;
(
  input wire logic               ref_clk,      // system clock
  input wire logic               rstn,         // sync reset, low
  input wire logic               csN,          // chip select
  input wire logic               soOe,         // so drive enable
  input wire logic [7:0]         statusByte,   // status snapshot
  input wire logic [7:0]         securityByte, // security word
  input wire logic               otpMode,      // otp mode on
  input wire logic               opStart,      // launch pulse
  input wire sfp_pkg::sfp_kind_t opKind,       // launched kind
  input wire logic               opOtp,        // otp target
  input wire logic               cmdRejected   // refusal pulse
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // ==========================================
  // launch steps
  sequence s_launch; opStart ##1 !opStart; endsequence
  sequence s_busy_run; statusByte[0] [*6]; endsequence
  chk_so_deselect: assert property (csN && $past(csN) |-> !soOe)
    else $error("so driven while deselected");
  chk_rej_pulse: assert property (cmdRejected |=> !cmdRejected)
    else $error("refusal pulse too long");
  chk_launch_once: assert property (opStart |-> s_launch)
    else $error("launch pulse too long");
  chk_chip_level: assert property (opStart && opKind == KIND_CHIP |-> statusByte[5:2] == 4'h0)
    else $error("chip erase with protect level set");
  chk_latch_launch: assert property (opStart |-> statusByte[1])
    else $error("launch without write enable");
  chk_busy_follows: assert property (opStart |-> ##[1:3] s_busy_run)
    else $error("busy missing after launch");
  chk_otp_route: assert property (opStart && otpMode |-> opKind == KIND_PROGRAM && opOtp)
    else $error("array access in otp mode");
  chk_lock_sticky: assert property ($past(securityByte[1]) |-> securityByte[1])
    else $error("customer lock cleared");
  chk_otp_locked: assert property (opStart && opOtp |-> securityByte[1:0] == 2'b00)
    else $error("program into locked otp");
  chk_stat_frozen: assert property (!csN [*6] |-> $stable(statusByte))
    else $error("status moved inside a frame");
endmodule

bind sfp_flash_front sfp_flash_front_chk i_chk (.ref_clk, .rstn, .csN, .soOe, .statusByte, .securityByte,
  .otpMode, .opStart, .opKind, .opOtp, .cmdRejected);

// file: bench/sfp_flash_front_tb.sv
// self-checking bench for the flash front end
// assumes sfp_host_model on the link and the bound checker
`timescale 1ns/10ps
module sfp_flash_front_tb;
  import sfp_pkg::*;
  localparam logic [7:0] ENTER = 8'hA1;
  localparam logic [7:0] LEAVE = 8'hA2;
  localparam logic [7:0] SECW  = 8'hA3;
  logic       ref_clk, rstn, sclk, csN, si, holdN, so, soOe, otpMode, opStart, opOtp, cmdRejected;
  logic       rej, started, oeHit, oeEnd, fb, strap;
  logic [7:0] statusByte, securityByte, rd;
  logic [23:0] opAddr;
  sfp_kind_t  opKind;
  int         num_errors, comparisons, cycles;

  sfp_flash_front #(.BUSY_CYCLES(16'h0008), .OP_OTP_ENTER(ENTER), .OP_OTP_EXIT(LEAVE), .OP_SEC_WRITE(SECW)) i_dut (
    .ref_clk(ref_clk), .rstn(rstn), .sclk(sclk), .csN(csN), .si(si), .holdN(holdN), .wpN(1'b1),
    .quadEnable(1'b0), .protect_from_bottom(fb), .individualMode(1'b0), .factoryLockStrap(strap),
    .so(so), .soOe(soOe), .statusByte(statusByte), .securityByte(securityByte), .otpMode(otpMode),
    .opStart(opStart), .opKind(opKind), .opAddr(opAddr), .opOtp(opOtp), .cmdRejected(cmdRejected));
  sfp_host_model i_host (.sclk(sclk), .csN(csN), .si(si), .holdN(holdN), .so(so), .soOe(soOe));

  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    if (num_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic run(input logic [39:0] tx, input int nb, input int nr = 0, input int hold = 99);
    @(posedge ref_clk);
    rej <= 1'b0;
    started <= 1'b0;
    oeHit <= 1'b0;
    @(posedge ref_clk);
    i_host.frame(tx, nb, nr, hold, rd, oeEnd);
    repeat (24) @(posedge ref_clk);
  endtask

  task automatic write_enable();
    run({OP_WR_ENABLE, 32'h0}, 8);
  endtask

  task automatic erase(input logic [23:0] a, input logic prot);
    write_enable();
    run({OP_SE, a, 8'h00}, 32);
    check("sector erase", {6'h0, rej, started}, {6'h0, prot, !prot});
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cmdRejected) rej <= 1'b1;
    if (opStart) started <= 1'b1;
    if (soOe) oeHit <= 1'b1;
    if (cycles == 40000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    rstn <= 1'b0;
    fb <= 1'b0;
    strap <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (8) @(posedge ref_clk);
    run({OP_RDSR, 32'h0}, 8, 8);
    check("idle status", rd, 8'h00);
    i_host.cpol = 1'b1;
    write_enable();
    run({OP_RDSR, 32'h0}, 8, 8);
    check("latch in mode 3", rd, 8'h02);
    check("status read drives so", {7'h0, oeHit}, 8'h01);
    i_host.cpol = 1'b0;
    run({OP_WRSR, 8'h04, 24'h0}, 16);
    check("status write", {4'h0, started, opKind}, {4'h0, 1'b1, KIND_STATUS});
    check("level in status", statusByte, 8'h04);
    write_enable();
    run({OP_CE_B, 32'h0}, 8);
    check("chip erase level 1", {6'h0, rej, started}, 8'h02);
    erase(24'h7F0000, 1'b1);
    erase(24'h7E0000, 1'b0);
    fb <= 1'b1;
    erase(24'h000000, 1'b1);
    erase(24'h010000, 1'b0);
    write_enable();
    run({OP_WRSR, 8'h20, 24'h0}, 16);
    erase(24'h7F0000, 1'b1);
    fb <= 1'b0;
    write_enable();
    run({OP_WRSR, 8'h1C, 24'h0}, 16);
    erase(24'h400000, 1'b1);
    erase(24'h3F0000, 1'b0);
    write_enable();
    run({OP_WRSR, 8'h00, 24'h0}, 16);
    write_enable();
    run({OP_CE_A, 32'h0}, 8);
    check("chip erase level 0", {4'h0, started, opKind}, {4'h0, 1'b1, KIND_CHIP});
    run({OP_WR_ENABLE, 32'h0}, 11);
    check("partial byte", {7'h0, rej}, 8'h01);
    run({OP_RDSR, 32'h0}, 8, 8);
    check("latch after partial", rd, 8'h00);
    run({8'hFF, 32'h0}, 8, 8);
    check("standby so", {7'h0, oeHit}, 8'h00);
    run({OP_RDSR, 32'h0}, 8, 8, 10);
    check("pause so", {7'h0, oeEnd}, 8'h00);
    run({OP_RDSR, 32'h0}, 8, 8);
    check("read after pause", rd, 8'h00);
    run({ENTER, 32'h0}, 8);
    check("otp mode on", {7'h0, otpMode}, 8'h01);
    write_enable();
    run({OP_PP, 24'h000010, 8'hAA}, 40);
    check("otp program", {6'h0, started, opOtp}, 8'h03);
    check("otp address", opAddr[7:0], 8'h10);
    write_enable();
    run({OP_SE, 32'h0}, 32);
    check("erase in otp", {6'h0, rej, started}, 8'h02);
    run({LEAVE, 32'h0}, 8);
    check("otp mode off", {7'h0, otpMode}, 8'h00);
    write_enable();
    run({SECW, 32'h0}, 8);
    check("customer lock", securityByte, 8'h02);
    run({8'hA4, 32'h0}, 8, 8);
    check("security read", rd, 8'h02);
    write_enable();
    run({SECW, 32'h0}, 8);
    check("second lock", {7'h0, rej}, 8'h01);
    run({ENTER, 32'h0}, 8);
    write_enable();
    run({OP_PP, 24'h000020, 8'h55}, 40);
    check("locked otp program", {7'h0, started}, 8'h00);
    run({LEAVE, 32'h0}, 8);
    rstn <= 1'b0;
    strap <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (8) @(posedge ref_clk);
    check("factory lock", securityByte, 8'h01);
    write_enable();
    run({SECW, 32'h0}, 8);
    check("lock after factory lock", {7'h0, rej}, 8'h01);
    close_out();
  end
endmodule

// file: bench/sfp_host_model.sv
// host controller model for the serial link, mode 0 or 3
// assumes one frame() call at a time from the bench
`timescale 1ns/10ps
module sfp_host_model (
  output logic      sclk,  // serial clock
  output logic      csN,   // chip select
  output logic      si,    // data to device
  output logic      holdN, // pause, low
  input  wire logic so,    // data from device
  input  wire logic soOe   // device drives so
);
  localparam int HALF = 16;
  logic cpol;
  initial begin
    cpol = 1'b0;
    sclk = 1'b0;
    csN = 1'b1;
    si = 1'b0;
    holdN = 1'b1;
  end
  // change on fall, sample on rise, nb + nr bits
  task automatic frame(input logic [39:0] tx, input int nb, input int nr, input int hold,
                       output logic [7:0] rd, output logic oeEnd);
    rd = 8'h00;
    sclk = cpol;
    #HALF;
    csN = 1'b0;
    #HALF;
    for (int i = 0; i < nb + nr; i++) begin
      sclk = 1'b0;
      if (i < nb) si = tx[39-i];
      if (i == hold) holdN = 1'b0;
      #HALF;
      sclk = 1'b1;
      if (i >= nb) rd = {rd[6:0], so};
      oeEnd = soOe;
      #HALF;
    end
    sclk = cpol;
    #HALF;
    csN = 1'b1;
    si = ~si;
    #HALF;
    holdN = 1'b1;
  endtask
endmodule

// file: rtl/sfp_flash_front.sv
// serial flash front end: command framing, pause, protection, otp
// assumes sclk from the host, csN idle high, quasi-static config ports
`timescale 1ns/10ps

// Notes on behaviour
// - top-down levels 1-7 protect 1..64 top blocks; 8-15 all; 0 none.
// - bottom-select set: same counts from block 0 upward; 8-15 all.
// - chip erase refused unless protect level is zero.
// - security bit 0 shows factory lock of the otp area.
// - enter otp, program, exit otp; programs go to otp while active.
// - security word write sets customer lock bit 1.
// - after any lock, otp content and lock state never change until the next reset.
// - otp mode blocks all main array access.
// - otp holds serial field 000-00F, customer field 010-1FF.
// - lock per 64 KB block, per 4 KB sector in end blocks.
// - unknown command: standby, output off, until next select.
// - known command: active until chip select rises.
// - sample on rising sclk, shift out on falling; modes 0 and 3.
// - data-out commands may end after any output bit.
// - write-type commands must end on a byte boundary or are dropped.
// - array access ignored while a write operation runs.
// - pause halts serial traffic only, never a running operation.
// - pause begins and ends only while sclk is low.
// - during pause: output off, input and clock ignored.
// - chip select high during pause resets the interface.
// - pause disabled in quad mode.
// - write enable latch needed before any altering command.
// - write-protect pin guards level and disable bits, not in quad.
module sfp_flash_front
  import sfp_pkg::*;
#(
  parameter logic [15:0] BUSY_CYCLES  = BUSY_CYCLES_DEF,
  parameter logic [7:0]  OP_OTP_ENTER = 8'hA1,
  parameter logic [7:0]  OP_OTP_EXIT  = 8'hA2,
  parameter logic [7:0]  OP_SEC_WRITE = 8'hA3,
  parameter logic [7:0]  OP_SEC_READ  = 8'hA4,
  parameter logic [7:0]  OP_LOCK_SET  = 8'hA5,
  parameter logic [7:0]  OP_LOCK_CLR  = 8'hA6
) (
  input  wire logic                       ref_clk,           // system clock
  input  wire logic                       rstn,              // sync reset, low
  input  wire logic                       sclk,              // serial clock
  input  wire logic                       csN,               // chip select, low
  input  wire logic                       si,                // serial data in
  input  wire logic                       holdN,             // pause, low
  input  wire logic                       wpN,               // write protect
  input  wire logic                       quadEnable,        // quad i/o mode
  input  wire logic                       protect_from_bottom, // bottom select
  input  wire logic                       individualMode,    // per-unit locks
  input  wire logic                       factoryLockStrap,  // factory lock
  output logic                            so,                // serial data out
  output logic                            soOe,              // so drive enable
  output logic [7:0]                      statusByte,        // status snapshot
  output logic [7:0]                      securityByte,      // security word
  output logic                            otpMode,           // otp mode on
  output logic                            opStart,           // launch pulse
  output sfp_pkg::sfp_kind_t              opKind,            // launched kind
  output logic [sfp_pkg::ADDR_W-1:0]      opAddr,            // launched address
  output logic                            opOtp,             // goes to otp area
  output logic                            cmdRejected        // refusal pulse
);

  // ==========================================
  // link domain
  sfp_link_t  linkState;
  logic       linkRst;
  logic       frameRst;
  logic [2:0] bitCnt;
  logic [6:0] shiftIn;
  logic [2:0] byteIdx;
  logic [7:0] opcode;
  logic [7:0] rxByte;
  logic       byteTog;
  logic       startTog;
  logic       holdMeta;
  logic       holdSync;
  logic       quadMeta;
  logic       quadSync;
  logic       holdAct;
  logic       replying;
  logic [7:0] replyByte;

  function automatic logic known(input logic [7:0] op);
    known = op inside {OP_WR_ENABLE, OP_WRDI, OP_RDSR, OP_WRSR, OP_PP, OP_SE,
                       OP_BE, OP_CE_A, OP_CE_B, OP_READ, OP_FREAD,
                       OP_OTP_ENTER, OP_OTP_EXIT, OP_SEC_WRITE, OP_SEC_READ,
                       OP_LOCK_SET, OP_LOCK_CLR};
  endfunction

  assign frameRst = csN | linkRst;

  always_ff @(posedge sclk or posedge frameRst) begin
    if (frameRst) begin
      bitCnt    <= 3'h0;
      shiftIn   <= 7'h00;
      byteIdx   <= 3'h0;
      opcode    <= 8'h00;
      linkState <= LK_CMD;
    end else if (!holdAct) begin
      shiftIn <= {shiftIn[5:0], si};
      bitCnt  <= bitCnt + 3'h1;
      if (bitCnt == 3'h7) begin
        if (byteIdx != 3'h7) begin
          byteIdx <= byteIdx + 3'h1;
        end
        if (byteIdx == 3'h0) begin
          opcode <= {shiftIn, si};
          linkState <= known({shiftIn, si}) ? LK_ACTIVE : LK_STANDBY;
        end
      end
    end
  end

  // bytes and byte starts handed to ref_clk by toggles
  always_ff @(posedge sclk or posedge linkRst) begin
    if (linkRst) begin
      byteTog  <= 1'b0;
      startTog <= 1'b0;
      rxByte   <= 8'h00;
    end else if (!holdAct && !csN && linkState != LK_STANDBY) begin
      if (bitCnt == 3'h0) begin
        startTog <= ~startTog;
      end
      if (bitCnt == 3'h7) begin
        byteTog <= ~byteTog;
        rxByte  <= {shiftIn, si};
      end
    end
  end

  // pause state only moves while sclk low
  always_ff @(negedge sclk or posedge frameRst) begin
    if (frameRst) begin
      holdMeta <= 1'b1;
      holdSync <= 1'b1;
      quadMeta <= 1'b0;
      quadSync <= 1'b0;
      holdAct  <= 1'b0;
    end else begin
      holdMeta <= holdN;
      holdSync <= holdMeta;
      quadMeta <= quadEnable;
      quadSync <= quadMeta;
      holdAct  <= !holdSync && !quadSync;
    end
  end

  assign replying  = linkState == LK_ACTIVE && byteIdx != 3'h0 &&
                     (opcode == OP_RDSR || opcode == OP_SEC_READ);
  assign replyByte = (opcode == OP_RDSR) ? statusByte : securityByte;

  // shift on falling edge, off in pause
  always_ff @(negedge sclk or posedge frameRst) begin
    if (frameRst) begin
      so   <= 1'b0;
      soOe <= 1'b0;
    end else if (holdAct) begin
      soOe <= 1'b0;
    end else begin
      soOe <= replying;
      so   <= replyByte[~bitCnt];
    end
  end

  // ==========================================
  // crossing into ref_clk
  logic [7:0] pinSync;
  logic       quadS;
  logic       bottomS;
  logic       unitS;
  logic       csS;
  logic       wpS;
  logic       byteS;
  logic       startS;
  logic       strapS;
  logic       csPrev;
  logic       bytePrev;
  logic       startPrev;
  logic       csRise;
  logic       byteEv;
  logic       startEv;

  sfp_sync #(
    .WIDTH   (8),
    .RST_VAL ({4'h0, PIN_SYNC_RST})
  ) u_pin_sync (
    .clk  (ref_clk),
    .rstn (rstn),
    .din  ({factoryLockStrap, quadEnable, protect_from_bottom, individualMode, csN, wpN, byteTog, startTog}),
    .dout (pinSync)
  );

  assign {strapS, quadS, bottomS, unitS, csS, wpS, byteS, startS} = pinSync;
  assign csRise  = csS && !csPrev;
  assign byteEv  = byteS ^ bytePrev;
  assign startEv = startS ^ startPrev;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      linkRst   <= 1'b1;
      csPrev    <= 1'b1;
      bytePrev  <= 1'b0;
      startPrev <= 1'b0;
    end else begin
      linkRst   <= 1'b0;
      csPrev    <= csS;
      bytePrev  <= byteS;
      startPrev <= startS;
    end
  end

  // ==========================================
  // frame collection
  logic [7:0]        frameOp;
  logic [7:0]        frameData;
  logic [ADDR_W-1:0] frameAddr;
  logic [2:0]        frameCnt;
  logic              partial;

  always_ff @(posedge ref_clk) begin
    if (!rstn || csRise) begin
      frameOp   <= 8'h00;
      frameData <= 8'h00;
      frameAddr <= '0;
      frameCnt  <= 3'h0;
    end else if (byteEv) begin
      if (frameCnt == 3'h0) begin
        frameOp <= rxByte;
      end else if (frameCnt <= 3'h3) begin
        frameAddr <= {frameAddr[15:0], rxByte};
      end
      if (frameCnt == 3'h1) begin
        frameData <= rxByte;
      end
      if (frameCnt != 3'h7) begin
        frameCnt <= frameCnt + 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn || csRise) begin
      partial <= 1'b0;
    end else if (startEv) begin
      partial <= 1'b1;
    end else if (byteEv) begin
      partial <= 1'b0;
    end
  end

  // ==========================================
  // protection state
  logic [LEVEL_W-1:0]    level;
  logic                  wrDisable;
  logic                  wrEnLatch;
  logic                  customerLock;
  logic                  factoryLock;
  logic                  strapTaken;
  logic [1:0]            strapWait;
  logic [LOCK_UNITS-1:0] lockBits;
  logic [15:0]           busyCnt;
  logic                  busy;
  logic                  busyDone;
  logic                  levelHit;
  logic                  unitHit;
  logic                  prot;
  logic                  pinLock;
  logic                  anyLock;
  logic                  cmdOk;

  function automatic logic [7:0] unitOf(input logic [ADDR_W-1:0] a);
    if (a[BLOCK_MSB:BLOCK_LSB] == BLOCK_FIRST) begin
      unitOf = {4'h0, a[SECTOR_MSB:SECTOR_LSB]};
    end else if (a[BLOCK_MSB:BLOCK_LSB] == BLOCK_LAST) begin
      unitOf = TOP_UNIT_BASE + {4'h0, a[SECTOR_MSB:SECTOR_LSB]};
    end else begin
      unitOf = {1'b0, a[BLOCK_MSB:BLOCK_LSB]} + MID_UNIT_OFS;
    end
  endfunction

  sfp_protect_decode u_decode (
    .level      (level),
    .fromBottom (bottomS),
    .block      (frameAddr[BLOCK_MSB:BLOCK_LSB]),
    .hit        (levelHit)
  );

  assign unitHit  = lockBits[unitOf(frameAddr)];
  assign prot     = unitS ? unitHit : levelHit;
  assign pinLock  = wrDisable && !wpS && !quadS;
  assign anyLock  = factoryLock || customerLock;
  assign busy     = busyCnt != 16'h0000;
  assign busyDone = busyCnt == 16'h0001;
  assign cmdOk    = csRise && !partial;

  // ==========================================
  // launch decision
  logic      launch;
  logic      isWrite;
  sfp_kind_t next_kind;

  always_comb begin
    launch    = 1'b0;
    isWrite   = 1'b1;
    next_kind = KIND_NONE;
    case (frameOp)
      OP_PP: begin
        next_kind = KIND_PROGRAM;
        // otp program into customer field only
        if (otpMode) begin
          launch = frameAddr[OTP_ADDR_W-1:0] >= OTP_CUST_FIRST && !anyLock;
        end else begin
          launch = !prot;
        end
        launch = launch && frameCnt >= 3'h5;
      end
      OP_SE, OP_BE: begin
        next_kind = (frameOp == OP_SE) ? KIND_SECTOR : KIND_BLOCK;
        // no array erase in otp mode
        launch = !otpMode && !prot && frameCnt == 3'h4;
      end
      OP_CE_A, OP_CE_B: begin
        next_kind = KIND_CHIP;
        launch = !otpMode && level == 4'h0 && frameCnt == 3'h1 &&
                 !(unitS && |lockBits);
      end
      OP_WRSR: begin
        next_kind = KIND_STATUS;
        launch = !pinLock && frameCnt >= 3'h2;
      end
      OP_SEC_WRITE, OP_LOCK_SET, OP_LOCK_CLR: begin
        // no second lock, no unit locks in otp mode
        launch = frameCnt == (frameOp == OP_SEC_WRITE ? 3'h1 : 3'h4) &&
                 !(frameOp == OP_SEC_WRITE ? anyLock : otpMode);
      end
      OP_WR_ENABLE, OP_WRDI, OP_OTP_ENTER, OP_OTP_EXIT: begin
        launch = frameCnt == 3'h1;
      end
      default: begin
        isWrite = 1'b0;
      end
    endcase
    if (frameOp != OP_WR_ENABLE && frameOp != OP_WRDI &&
        frameOp != OP_OTP_ENTER && frameOp != OP_OTP_EXIT) begin
      launch = launch && wrEnLatch;
    end
    launch = launch && !busy && isWrite;
  end

  // ==========================================
  // state updates
  // write enable latch
  always_ff @(posedge ref_clk) begin
    if (!rstn || busyDone) begin
      wrEnLatch <= 1'b0;
    end else if (cmdOk && launch) begin
      wrEnLatch <= frameOp == OP_WR_ENABLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      level     <= 4'h0;
      wrDisable <= 1'b0;
    end else if (cmdOk && launch && frameOp == OP_WRSR) begin
      level     <= frameData[5:2];
      wrDisable <= frameData[7];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      busyCnt <= 16'h0000;
    end else if (cmdOk && launch && next_kind != KIND_NONE) begin
      busyCnt <= BUSY_CYCLES;
    end else if (busy) begin
      busyCnt <= busyCnt - 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      otpMode <= 1'b0;
    end else if (cmdOk && launch && frameOp == OP_OTP_ENTER) begin
      otpMode <= 1'b1;
    end else if (cmdOk && launch && frameOp == OP_OTP_EXIT) begin
      otpMode <= 1'b0;
    end
  end

  // lock bits, strap caught after release
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      factoryLock  <= 1'b0;
      strapTaken   <= 1'b0;
      strapWait    <= 2'h0;
      customerLock <= 1'b0;
    end else begin
      // strap valid only once through the synchroniser
      if (!strapTaken) begin
        factoryLock <= strapS;
        strapWait   <= strapWait + 2'h1;
        strapTaken  <= strapWait == 2'h2;
      end
      if (cmdOk && launch && frameOp == OP_SEC_WRITE && !anyLock) begin
        customerLock <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      lockBits <= '0;
    end else if (cmdOk && launch && !otpMode) begin
      if (frameOp == OP_LOCK_SET) begin
        lockBits[unitOf(frameAddr)] <= 1'b1;
      end else if (frameOp == OP_LOCK_CLR) begin
        lockBits[unitOf(frameAddr)] <= 1'b0;
      end
    end
  end

  // operation launch port
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      opStart     <= 1'b0;
      opKind      <= KIND_NONE;
      opAddr      <= '0;
      opOtp       <= 1'b0;
      cmdRejected <= 1'b0;
    end else begin
      opStart     <= cmdOk && launch && next_kind != KIND_NONE;
      cmdRejected <= csRise && isWrite && (partial || !launch);
      if (cmdOk && launch && next_kind != KIND_NONE) begin
        opKind <= next_kind;
        opAddr <= frameAddr;
        opOtp  <= otpMode;
      end
    end
  end

  // snapshots only move while deselected, so the link reads them stable
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      statusByte   <= 8'h00;
      securityByte <= 8'h00;
    end else if (csS) begin
      statusByte <= {wrDisable, quadS, level, wrEnLatch, busy};
      securityByte <= '0;
      securityByte[SEC_FACTORY]  <= factoryLock;
      securityByte[SEC_CUSTOMER] <= customerLock;
    end
  end

endmodule

// file: rtl/sfp_pkg.sv
// shared constants of the serial flash protect and bus front end
// assumes one 64 Mbit array of 128 blocks of 64 KB, 4 KB sectors
package sfp_pkg;

  // ==========================================
  // array geometry
  localparam int          ADDR_W        = 24;
  localparam int          BLOCK_W       = 7;
  localparam int          SECTOR_W      = 4;
  localparam int          LEVEL_W       = 4;
  localparam int          OTP_ADDR_W    = 9;
  localparam logic [7:0]  BLOCK_SPAN    = 8'h80;
  localparam logic [6:0]  BLOCK_FIRST   = 7'h00;
  localparam logic [6:0]  BLOCK_LAST    = 7'h7F;
  localparam int          BLOCK_MSB     = 22;
  localparam int          BLOCK_LSB     = 16;
  localparam int          SECTOR_MSB    = 15;
  localparam int          SECTOR_LSB    = 12;

  // ==========================================
  // individual lock units: 16 + 126 + 16
  localparam int          LOCK_UNITS    = 158;
  localparam logic [7:0]  MID_UNIT_OFS  = 8'h0F;
  localparam logic [7:0]  TOP_UNIT_BASE = 8'h8E;

  // ==========================================
  // one-time-programmable area
  localparam logic [8:0]  OTP_SERIAL_LAST = 9'h00F;
  localparam logic [8:0]  OTP_CUST_FIRST  = 9'h010;
  localparam logic [8:0]  OTP_LAST        = 9'h1FF;
  localparam int          SEC_FACTORY     = 0;
  localparam int          SEC_CUSTOMER    = 1;

  // ==========================================
  // command codes
  localparam logic [7:0]  OP_WR_ENABLE = 8'h06;
  localparam logic [7:0]  OP_WRDI  = 8'h04;
  localparam logic [7:0]  OP_RDSR  = 8'h05;
  localparam logic [7:0]  OP_WRSR  = 8'h01;
  localparam logic [7:0]  OP_PP    = 8'h02;
  localparam logic [7:0]  OP_SE    = 8'h20;
  localparam logic [7:0]  OP_BE    = 8'hD8;
  localparam logic [7:0]  OP_CE_A  = 8'h60;
  localparam logic [7:0]  OP_CE_B  = 8'hC7;
  localparam logic [7:0]  OP_READ  = 8'h03;
  localparam logic [7:0]  OP_FREAD = 8'h0B;

  // ==========================================
  // timing and reset values
  localparam logic [15:0] BUSY_CYCLES_DEF = 16'h0100;
  localparam logic [3:0]  PIN_SYNC_RST    = 4'hC;

  // ==========================================
  // types
  typedef enum logic [2:0] {
    LK_CMD     = 3'b001,
    LK_ACTIVE  = 3'b010,
    LK_STANDBY = 3'b100
  } sfp_link_t;

  typedef enum logic [2:0] {
    KIND_NONE    = 3'h0,
    KIND_PROGRAM = 3'h1,
    KIND_SECTOR  = 3'h2,
    KIND_BLOCK   = 3'h3,
    KIND_CHIP    = 3'h4,
    KIND_STATUS  = 3'h5
  } sfp_kind_t;

endpackage

// file: rtl/sfp_protect_decode.sv
// protect level to protected block decode
// assumes a pure combinational lookup of one block
`timescale 1ns/10ps
module sfp_protect_decode
  import sfp_pkg::*;
(
  input  wire logic [sfp_pkg::LEVEL_W-1:0] level,       // protect level code
  input  wire logic                        fromBottom,  // count from block 0
  input  wire logic [sfp_pkg::BLOCK_W-1:0] block,       // block to test
  output logic                             hit          // block protected
);
  logic [7:0] span;

  always_comb begin
    span = 8'h01 << (level[2:0] - 3'h1);
    if (level[3]) begin
      hit = 1'b1;
    end else if (level == 4'h0) begin
      hit = 1'b0;
    end else if (fromBottom) begin
      hit = {1'b0, block} < span;
    end else begin
      hit = {1'b0, block} >= (BLOCK_SPAN - span);
    end
  end
endmodule

// file: rtl/sfp_sync.sv
// two-flop level synchroniser, synchronous active-low reset
// assumes each bit is an independent level
`timescale 1ns/10ps
module sfp_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,   // destination clock
  input  wire logic             rstn,  // sync reset, active low
  input  wire logic [WIDTH-1:0] din,   // asynchronous levels
  output logic      [WIDTH-1:0] dout   // synchronised levels
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule
